/* peap_pkg.sv */
package peap_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // clock and timing figures
  localparam int CLK_PERIOD_NS     = 40;
  localparam int READ_ACCESS_NS    = 300;
  localparam int OE_SETUP_NS       = 10;
  localparam int WRITE_PULSE_NS    = 150;
  localparam int ADDR_HOLD_NS      = 70;
  localparam int BUSY_ASSERT_DELAY_NS = 100;
  localparam int PROGRAM_DURATION_MS  = 40;
  localparam int POWERUP_LOCKOUT_MS   = 10;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  // least times round up, three extra cycles on read and busy wait for pin synchronisers
  localparam int READ_CYC     = cyc_up(READ_ACCESS_NS) + 3;
  localparam int SETUP_CYC    = cyc_up(OE_SETUP_NS);
  localparam int PULSE_CYC    = cyc_up(WRITE_PULSE_NS);
  localparam int HOLD_CYC     = cyc_up(ADDR_HOLD_NS);
  localparam int BUSY_WAIT_CYC = cyc_up(BUSY_ASSERT_DELAY_NS) + 3;
  localparam int PROG_TOUT_DEF = PROGRAM_DURATION_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOCKOUT_DEF   = POWERUP_LOCKOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 21;

  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 21'h000001;

  typedef enum logic [0:0] {
    PEAP_MODE_STROBE = 1'b0,
    PEAP_MODE_SELECT = 1'b1
  } peap_wmode_t;

  typedef struct packed {
    logic              write;
    peap_wmode_t       wmode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } peap_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic              chip_sel_n;
    logic              out_gate_n;
    logic              wr_strobe_n;
  } peap_pins_t;

  typedef enum logic [2:0] {
    PEAP_IDLE  = 3'b000,
    PEAP_RD    = 3'b001,
    PEAP_SETUP = 3'b010,
    PEAP_PULSE = 3'b011,
    PEAP_HOLD  = 3'b100,
    PEAP_BWAIT = 3'b101,
    PEAP_PROG  = 3'b110
  } peap_state_t;

endpackage : peap_pkg

/* peap_sync.sv */
`timescale 1ns/1ps
module peap_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_reg <= '1;
      s2_reg <= '1;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule : peap_sync

/* peap_host.sv */
`timescale 1ns/1ps
module peap_host
  import peap_pkg::*;
#(
  parameter int PROG_TOUT  = PROG_TOUT_DEF,
  parameter int LOCKOUT_CYC = LOCKOUT_DEF
) (
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic                    req_valid,
  input  wire peap_pkg::peap_req_t     req,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [peap_pkg::DATA_W-1:0]  rsp_data,
  output logic                         rsp_timeout,
  output logic                         lockout_busy,
  output peap_pkg::peap_pins_t         pins,
  input  wire logic [peap_pkg::DATA_W-1:0] din,
  input  wire logic                    ready_busy_pin
);
  import peap_pkg::*;

  localparam logic [CNT_W-1:0] RD_N    = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] HOLD_N  = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] BWAIT_N = CNT_W'(BUSY_WAIT_CYC);
  localparam logic [CNT_W-1:0] PROG_N  = CNT_W'(PROG_TOUT);
  localparam logic [CNT_W-1:0] LOCK_N  = CNT_W'(LOCKOUT_CYC);

  logic [DATA_W-1:0] din_s;
  logic [0:0]        rb_s;

  peap_sync #(.W(DATA_W)) u_sync_d (
    .mclk (mclk),
    .srst (srst),
    .d    (din),
    .q    (din_s)
  );
  peap_sync #(.W(1)) u_sync_rb (
    .mclk (mclk),
    .srst (srst),
    .d    (ready_busy_pin),
    .q    (rb_s)
  );

  peap_state_t       state_reg,   state_next;
  logic [CNT_W-1:0]  cnt_reg,     cnt_next;
  logic [CNT_W-1:0]  lock_reg,    lock_next;
  peap_pins_t        pins_reg,    pins_next;
  peap_wmode_t       mode_reg,    mode_next;
  logic              ready_reg,   ready_next;
  logic              rv_reg,      rv_next;
  logic [DATA_W-1:0] rd_reg,      rd_next;
  logic              to_reg,      to_next;
  logic              lk_reg,      lk_next;

  function automatic peap_pins_t idle_pins(input peap_pins_t p);
    peap_pins_t q;
    q             = p;
    q.chip_sel_n  = 1'b1;
    q.out_gate_n  = 1'b1;
    q.wr_strobe_n = 1'b1;
    q.dout_oe     = 1'b0;
    return q;
  endfunction : idle_pins

  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != CNT_ZERO) ? cnt_reg - CNT_ONE : CNT_ZERO;
    lock_next  = (lock_reg != CNT_ZERO) ? lock_reg - CNT_ONE : CNT_ZERO;
    lk_next    = (lock_next != CNT_ZERO);
    pins_next  = pins_reg;
    mode_next  = mode_reg;
    ready_next = 1'b0;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    to_next    = 1'b0;
    case (state_reg)
      PEAP_IDLE: begin
        pins_next  = idle_pins(pins_reg);
        // accept only while device shows ready
        ready_next = rb_s[0];
        if (req_valid && ready_reg && rb_s[0]) begin
          ready_next       = 1'b0;
          pins_next.addr   = req.addr;
          mode_next        = req.wmode;
          if (!req.write) begin
            // address stays on the pins for the whole read
            pins_next.chip_sel_n = 1'b0;
            // gate low only for reads, never tied low
            pins_next.out_gate_n = 1'b0;
            cnt_next   = RD_N;
            state_next = PEAP_RD;
          end else if (lock_reg == CNT_ZERO) begin
            // gate held high through the write
            pins_next.dout    = req.wdata;
            pins_next.dout_oe = 1'b1;
            if (req.wmode == PEAP_MODE_SELECT) begin
              pins_next.wr_strobe_n = 1'b0;
            end else begin
              pins_next.chip_sel_n = 1'b0;
            end
            cnt_next   = SETUP_N;
            state_next = PEAP_SETUP;
          end else begin
            to_next = 1'b1;
            rv_next = 1'b1;
          end
        end
      end
      PEAP_RD: begin
        // sample after the access time has run out
        if (cnt_reg == CNT_ONE) begin
          rd_next    = din_s;
          rv_next    = 1'b1;
          pins_next  = idle_pins(pins_reg);
          state_next = PEAP_IDLE;
        end
      end
      PEAP_SETUP: begin
        if (cnt_reg == CNT_ONE) begin
          if (mode_reg == PEAP_MODE_SELECT) begin
            pins_next.chip_sel_n = 1'b0;
          end else begin
            pins_next.wr_strobe_n = 1'b0;
          end
          cnt_next   = PULSE_N;
          state_next = PEAP_PULSE;
        end
      end
      PEAP_PULSE: begin
        if (cnt_reg == CNT_ONE) begin
          if (mode_reg == PEAP_MODE_SELECT) begin
            pins_next.chip_sel_n = 1'b1;
          end else begin
            pins_next.wr_strobe_n = 1'b1;
          end
          cnt_next   = HOLD_N;
          state_next = PEAP_HOLD;
        end
      end
      PEAP_HOLD: begin
        if (cnt_reg == CNT_ONE) begin
          // strobe rise ends a select write
          pins_next  = idle_pins(pins_reg);
          cnt_next   = BWAIT_N;
          state_next = PEAP_BWAIT;
        end
      end
      PEAP_BWAIT: begin
        // busy must show within the assert delay
        if (!rb_s[0]) begin
          cnt_next   = PROG_N;
          state_next = PEAP_PROG;
        end else if (cnt_reg == CNT_ONE) begin
          to_next    = 1'b1;
          rv_next    = 1'b1;
          state_next = PEAP_IDLE;
        end
      end
      PEAP_PROG: begin
        // ready high ends the program cycle
        if (rb_s[0]) begin
          rv_next    = 1'b1;
          state_next = PEAP_IDLE;
        end else if (cnt_reg == CNT_ONE) begin
          to_next    = 1'b1;
          rv_next    = 1'b1;
          state_next = PEAP_IDLE;
        end
      end
      default: begin
        pins_next  = idle_pins(pins_reg);
        state_next = PEAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= PEAP_IDLE;
      cnt_reg   <= CNT_ZERO;
      lock_reg  <= LOCK_N;
      pins_reg  <= '{addr: '0, dout: '0, dout_oe: 1'b0, chip_sel_n: 1'b1,
                     out_gate_n: 1'b1, wr_strobe_n: 1'b1};
      mode_reg  <= PEAP_MODE_STROBE;
      ready_reg <= 1'b0;
      rv_reg    <= 1'b0;
      rd_reg    <= '0;
      to_reg    <= 1'b0;
      lk_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      lock_reg  <= lock_next;
      pins_reg  <= pins_next;
      mode_reg  <= mode_next;
      ready_reg <= ready_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      to_reg    <= to_next;
      lk_reg    <= lk_next;
    end
  end

  assign pins         = pins_reg;
  assign req_ready    = ready_reg;
  assign rsp_valid    = rv_reg;
  assign rsp_data     = rd_reg;
  assign rsp_timeout  = to_reg;
  assign lockout_busy = lk_reg;

  // gate high whenever strobe is low
  a_gate_during_write: assert property (@(posedge mclk) disable iff (srst)
    !pins_reg.wr_strobe_n |-> pins_reg.out_gate_n)
    else $error("output gate low during write strobe");

  a_read_addr_stable: assert property (@(posedge mclk) disable iff (srst)
    (state_reg == PEAP_RD) && $past(state_reg == PEAP_RD) |-> $stable(pins_reg.addr))
    else $error("address moved during read");

  // in strobe mode, strobe falls only with select already low
  a_strobe_after_sel: assert property (@(posedge mclk) disable iff (srst)
    $fell(pins_reg.wr_strobe_n) && mode_reg == PEAP_MODE_STROBE |->
      $past(!pins_reg.chip_sel_n))
    else $error("strobe fell before select");

  // in select mode, select falls only with strobe already low
  a_sel_after_strobe: assert property (@(posedge mclk) disable iff (srst)
    $fell(pins_reg.chip_sel_n) && state_reg == PEAP_PULSE && mode_reg == PEAP_MODE_SELECT
      |-> $past(!pins_reg.wr_strobe_n))
    else $error("select fell before strobe");

  sequence s_pulse_start;
    state_reg == PEAP_SETUP && state_next == PEAP_PULSE;
  endsequence
  // write pulse lasts the least pulse width
  a_pulse_width: assert property (@(posedge mclk) disable iff (srst)
    s_pulse_start |=> (state_reg == PEAP_PULSE) [*4])
    else $error("write pulse too short");

  // no access starts while device busy
  a_wait_ready: assert property (@(posedge mclk) disable iff (srst)
    state_reg == PEAP_IDLE && state_next != PEAP_IDLE |-> rb_s[0])
    else $error("access started while busy");

  a_no_write_lock: assert property (@(posedge mclk) disable iff (srst)
    state_next == PEAP_SETUP && state_reg == PEAP_IDLE |-> lock_reg == CNT_ZERO)
    else $error("write during lockout");

  // read answer comes after the access time
  a_read_latency: assert property (@(posedge mclk) disable iff (srst)
    state_reg == PEAP_IDLE && state_next == PEAP_RD |-> ##12 rv_reg)
    else $error("read answer not on time");

endmodule : peap_host

/* peap_dev_model.sv */
`timescale 1ns/1ps
module peap_dev_model #(
  parameter int LOCK = 40
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic                   slow,
  input  wire peap_pkg::peap_pins_t   pins,
  output logic [peap_pkg::DATA_W-1:0] din,
  output logic                        ready_busy_pin
);
  import peap_pkg::*;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] lat_d, last = '0;
  logic [ADDR_W-1:0] lat_a, a_q;
  logic              cs_q = 1'b1, we_q = 1'b1, pend = 1'b0;
  int                lock = 0, dly = 0, prog = 0, acc = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  wire cs_fl = cs_q & ~pins.chip_sel_n;
  wire we_fl = we_q & ~pins.wr_strobe_n;
  wire we_rs = ~we_q & pins.wr_strobe_n;
  wire d_ev = (we_rs & ~pins.chip_sel_n) | (~cs_q & pins.chip_sel_n & ~pins.wr_strobe_n);
  wire ok = (lock == 0) & pins.out_gate_n;
  always @(posedge mclk) begin
    cs_q <= pins.chip_sel_n;
    we_q <= pins.wr_strobe_n;
    if (srst) begin
      lock <= LOCK;
      dly <= 0;
      prog <= 0;
      pend <= 1'b0;
    end else begin
      if (lock > 0) lock <= lock - 1;
      if ((cs_fl & ~pins.wr_strobe_n) | (we_fl & ~pins.chip_sel_n)) lat_a <= pins.addr;
      if (d_ev) lat_d <= pins.dout;
      if (d_ev) pend <= 1'b1;
      if (we_rs & (pend | d_ev) & ok) dly <= 2;
      if (we_rs) pend <= 1'b0;
      if (dly == 1) prog <= slow ? 300 : 60;
      if (dly > 0) dly <= dly - 1;
      if (prog == 1) mem[lat_a] <= lat_d;
      if (prog > 0) prog <= prog - 1;
    end
  end
  always @(posedge mclk) begin
    a_q <= pins.addr;
    if (pins.chip_sel_n | pins.out_gate_n | (pins.addr != a_q)) acc <= 0;
    else if (acc < 3) acc <= acc + 1;
    if (acc == 3 && prog == 0) last <= mem[pins.addr];
    else last <= ~last;
  end
  assign din = last;
  assign ready_busy_pin = (prog == 0);
endmodule : peap_dev_model

/* parallel_eeprom_access_port_tb_top.sv */
`timescale 1ns/1ps
module parallel_eeprom_access_port_tb_top;
  import peap_pkg::*;
  logic              mclk = 1'b0, srst = 1'b1, req_valid = 1'b0, slow = 1'b0;
  peap_req_t         req = '0;
  logic              req_ready, rsp_valid, rsp_timeout, lockout_busy, rdy, to;
  logic [DATA_W-1:0] rsp_data, din, rd, d;
  logic [ADDR_W-1:0] a;
  peap_pins_t        pins;
  logic [DATA_W-1:0] ref_mem [256];
  int                n_fail = 0, check_count = 0, seed = 32'hf8cfed17;
  peap_host #(.PROG_TOUT(200), .LOCKOUT_CYC(50)) dut (
    .mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .lockout_busy(lockout_busy), .pins(pins),
    .din(din), .ready_busy_pin(rdy));
  peap_dev_model #(.LOCK(40)) dev (
    .mclk(mclk), .srst(srst), .slow(slow), .pins(pins), .din(din),
    .ready_busy_pin(rdy));
  always #20 mclk = ~mclk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    return ref_mem[ad];
  endfunction : exp_rd
  task automatic xfer(input logic w, input logic m, input logic [7:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{write: w, wmode: peap_wmode_t'(m), addr: ad, wdata: dt};
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    rd = rsp_data;
    to = rsp_timeout;
    if (n >= 5000) begin
      n_fail++;
      conclude();
    end
  endtask : xfer
  initial begin
    #(40 * 30000);
    n_fail++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 256; i++) ref_mem[i] = 8'hFF;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk1("lockout flag", 1'b1, lockout_busy);
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, m[0], 8'h10, 8'h55);
      chk1("refused write", 1'b1, to);
    end
    xfer(1'b0, 1'b0, 8'h10, 8'h00);
    chk8("lockout read", exp_rd(8'h10), rd);
    repeat (40) @(negedge mclk);
    chk1("lockout cleared", 1'b0, lockout_busy);
    $display("test lockout done");
    for (int i = 0; i < 14; i++) begin
      a = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      xfer(1'b1, i[0], a, d);
      chk1("write status", 1'b0, to);
      ref_mem[a] = d;
      xfer(1'b0, 1'b0, a, 8'h00);
      chk8("read back", exp_rd(a), rd);
      a = 8'($random(seed));
      xfer(1'b0, 1'b0, a, 8'h00);
      chk8("random read", exp_rd(a), rd);
    end
    $display("test write read done");
    slow <= 1'b1;
    xfer(1'b1, 1'b1, 8'h3C, 8'hA5);
    chk1("slow write", 1'b1, to);
    slow <= 1'b0;
    ref_mem[8'h3C] = 8'hA5;
    xfer(1'b0, 1'b0, 8'h3C, 8'h00);
    chk8("read after slow", exp_rd(8'h3C), rd);
    $display("test slow done");
    conclude();
  end
endmodule : parallel_eeprom_access_port_tb_top
